// ===== src/tplic_cfg.svh
// Purpose: Offsets, bit positions, reset values and counts of the irq controller
// Assumes: Byte addresses on a 32-bit AXI4-Lite register bus
// Notes:   Definitions only
`ifndef TPLIC_CFG_SVH
`define TPLIC_CFG_SVH

// Register byte offsets
`define TPLIC_OFF_ICR      8'h00
`define TPLIC_OFF_RCR      8'h04
`define TPLIC_OFF_FLAG     8'h08
`define TPLIC_OFF_EN       8'h0c
`define TPLIC_OFF_PRI      8'h10
`define TPLIC_OFF_CFG      8'h14
`define TPLIC_OFF_PORT     8'h18
`define TPLIC_OFF_STAT     8'h1c

// Fields of irq_control_register
`define TPLIC_ICR_HI       7
`define TPLIC_ICR_LO       6
`define TPLIC_ICR_CHG_EN   5
`define TPLIC_ICR_EXT_EN   4
`define TPLIC_ICR_EXT_FLAG 1
`define TPLIC_ICR_CHG_FLAG 0

// Field of reset_control_register
`define TPLIC_RCR_PME      7

// Fields of the core source configuration register
`define TPLIC_CFG_EDGE     6
`define TPLIC_CFG_EXT_PRI  1
`define TPLIC_CFG_CHG_PRI  0

// Fields of the status register
`define TPLIC_STAT_HI      0
`define TPLIC_STAT_LO      1
`define TPLIC_STAT_ARM     2

// Reset values
`define TPLIC_RST_EDGE     1'b1
`define TPLIC_RST_PRI      1'b1

// Entry addresses
`define TPLIC_VEC_HIGH     16'h0008
`define TPLIC_VEC_LOW      16'h0018

// Instruction boundaries a request waits before redirection
`define TPLIC_ARM_CYCLES   2'h2

// AXI responses
`define TPLIC_RESP_OKAY    2'h0
`define TPLIC_RESP_SLVERR  2'h2

`endif

// ===== src/tplic_pkg.sv
// Purpose: Types shared by the irq controller files
// Assumes: 32-bit AXI4-Lite data, 8-bit address decode
// Notes:   Constants live in tplic_cfg.svh
package tplic_pkg;

  // AXI4-Lite master to slave
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } tplic_axil_req_t;

  // AXI4-Lite slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tplic_axil_rsp_t;

  // Redirection request to the core sequencer
  typedef struct packed {
    logic        redirect;
    logic        push_return;
    logic [15:0] vector;
  } tplic_core_t;

  // Acceptance sequencer
  typedef enum logic [0:0] {
    TPLIC_IDLE  = 1'b0,
    TPLIC_ARMED = 1'b1
  } tplic_state_t;

endpackage

// ===== src/tplic_flag_bank.sv
// Purpose: Bank of sticky pending flags
// Assumes: Write strobes are one-cycle pulses; set inputs may be held for many cycles
// Notes:   A hardware set beats a software write in the same cycle
`timescale 1ns/10ps
`default_nettype none
module tplic_flag_bank #(
  parameter int N = 10
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [N-1:0] set_i,
  input  wire logic [N-1:0] wr_en,
  input  wire logic [N-1:0] wr_val,
  output var  logic [N-1:0] flags_r
);
  import tplic_pkg::*;

  // One flop per source
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flags_r[i] <= 1'b0;
        end else if (set_i[i]) begin
          // Event wins, so none is lost on a clear
          flags_r[i] <= 1'b1;
        end else if (wr_en[i]) begin
          flags_r[i] <= wr_val[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== src/tplic_top.sv
// Purpose: Two-level priority interrupt controller with AXI4-Lite registers
// Assumes: instr_boundary pulses once per instruction cycle from the core
// Notes:   Summary of operation follows
// Summary of operation
// - Entry addresses 0008h high, 0018h low
// - High request preempts running low routine
// - Each source has flag, enable, priority
// - Priority mode only while mode bit set
// - High enable gates high, low gates low
// - Qualified source redirects to its vector
// - Source enable masks only that source
// - Mode bit resets clear; priorities ignored
// - Compatibility: bit6 peripheral, bit7 global enable
// - Compatibility mode always uses 0008h
// - Acceptance clears the permitting global enable
// - Low requests held during high routine
// - Core pushes return, loads entry address
// - Return operation sets applicable global enable
// - Pin event latency three to four cycles
// - Flags set regardless of any enable
// - Edge select: 1 rising, 0 falling
// - Mismatch keeps setting flag until read
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "tplic_cfg.svh"
module tplic_top #(
  parameter int NPER = 8,
  parameter int NCHG = 4
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire tplic_pkg::tplic_axil_req_t axi_req,
  output var  tplic_pkg::tplic_axil_rsp_t axi_rsp,
  input  wire logic                      instr_boundary,
  input  wire logic                      ret_op,
  input  wire logic                      ext0_pin,
  input  wire logic [NCHG-1:0]           change_sense_port,
  input  wire logic [NPER-1:0]           per_event,
  output var  tplic_pkg::tplic_core_t    core_out
);
  import tplic_pkg::*;

  localparam int NSRC = NPER + 2;   // Peripherals, ext0, port change
  localparam int IEXT = NPER;       // Index of ext0 source
  localparam int ICHG = NPER + 1;   // Index of port change source

  // Bus slave state
  logic        awready_r;           // Write address accept
  logic        wready_r;            // Write data accept
  logic        bvalid_r;            // Write response valid
  logic [1:0]  bresp_r;             // Write response code
  logic        arready_r;           // Read address accept
  logic        rvalid_r;            // Read data valid
  logic [31:0] rdata_r;             // Read data
  logic [1:0]  rresp_r;             // Read response code
  logic        aw_got_r;            // Address held
  logic        w_got_r;             // Data held
  logic [7:0]  waddr_r;             // Held write address
  logic [7:0]  wdata_r;             // Held low write byte
  logic        wlane_r;             // Low byte lane enabled

  // Control registers
  logic            glb_hi_r;        // global_irq_enable / global_high_enable
  logic            glb_lo_r;        // peripheral_irq_enable / global_low_enable
  logic            chg_en_r;        // Port change enable
  logic            ext_en_r;        // ext0 enable
  logic            priority_mode_enable_r;
  logic [NPER-1:0] per_en_r;        // peripheral_enable_reg_1
  logic [NPER-1:0] per_pri_r;       // peripheral_priority_reg_1
  logic            ext0_edge_select_r;
  logic            ext_pri_r;       // ext0 priority
  logic            chg_pri_r;       // Port change priority

  // Source sampling and service state
  logic            ext_smp_r;       // ext0 level at last boundary
  logic            ext_prev_r;      // ext0 level one boundary before
  logic [NCHG-1:0] chg_smp_r;       // Port level at last boundary
  logic [NCHG-1:0] port_latch_r;    // Port value at last read
  logic            in_high_r;       // High routine running
  logic            in_low_r;        // Low routine running
  tplic_state_t    state_r;         // Acceptance sequencer
  logic [1:0]      arm_cnt_r;       // Boundaries left before redirect
  logic            redirect_r;      // Redirect pulse to core
  logic            push_r;          // Push-return pulse to core
  logic [15:0]     vector_r;        // Entry address to core

  // Handshakes and decode
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_do;
  logic aw_got_nxt;
  logic w_got_nxt;
  logic bvalid_nxt;
  logic rvalid_nxt;
  logic wr_icr;
  logic wr_rcr;
  logic wr_flag;
  logic wr_en;
  logic wr_pri;
  logic wr_cfg;
  logic wr_hit;

  // Flags and qualification
  logic [NSRC-1:0] flags;
  logic [NSRC-1:0] ev_set;
  logic [NSRC-1:0] fl_wr;
  logic [NSRC-1:0] fl_val;
  logic [NSRC-1:0] src_en;
  logic [NSRC-1:0] src_pri;
  logic [NSRC-1:0] src_per;
  logic [NSRC-1:0] active;
  logic            ext_edge;
  logic            chg_mis;
  logic            cmp_req;
  logic            hi_req;
  logic            lo_req;
  logic            take_hi;
  logic            take_lo;
  logic            fire;

  // Channel handshakes; a write lands once both halves are held
  assign aw_hs = axi_req.awvalid & awready_r;
  assign w_hs  = axi_req.wvalid & wready_r;
  assign ar_hs = axi_req.arvalid & arready_r;
  assign wr_do = aw_got_r & w_got_r & ~bvalid_r;

  // Next values used to keep every ready a flop
  always_comb begin
    aw_got_nxt = (aw_got_r | aw_hs) & ~wr_do;
    w_got_nxt  = (w_got_r | w_hs) & ~wr_do;
    bvalid_nxt = wr_do | (bvalid_r & ~axi_req.bready);
    rvalid_nxt = ar_hs | (rvalid_r & ~axi_req.rready);
  end

  // Write channel state; address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `TPLIC_RESP_OKAY;
    end else begin
      aw_got_r  <= aw_got_nxt;
      w_got_r   <= w_got_nxt;
      // Ready drops while a half is held or a response waits
      awready_r <= ~aw_got_nxt & ~bvalid_nxt;
      wready_r  <= ~w_got_nxt & ~bvalid_nxt;
      bvalid_r  <= bvalid_nxt;
      if (wr_do) begin
        bresp_r <= wr_hit ? `TPLIC_RESP_OKAY : `TPLIC_RESP_SLVERR;
      end
    end
  end

  // Held write payload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waddr_r <= 8'h00;
      wdata_r <= 8'h00;
      wlane_r <= 1'b0;
    end else begin
      if (aw_hs) begin
        waddr_r <= axi_req.awaddr;
      end
      if (w_hs) begin
        wdata_r <= axi_req.wdata[7:0];
        wlane_r <= axi_req.wstrb[0];
      end
    end
  end

  // Write decode; registers are 8 bits wide in lane 0
  always_comb begin
    wr_icr  = wr_do & wlane_r & (waddr_r == `TPLIC_OFF_ICR);
    wr_rcr  = wr_do & wlane_r & (waddr_r == `TPLIC_OFF_RCR);
    wr_flag = wr_do & wlane_r & (waddr_r == `TPLIC_OFF_FLAG);
    wr_en   = wr_do & wlane_r & (waddr_r == `TPLIC_OFF_EN);
    wr_pri  = wr_do & wlane_r & (waddr_r == `TPLIC_OFF_PRI);
    wr_cfg  = wr_do & wlane_r & (waddr_r == `TPLIC_OFF_CFG);
    // Port and status are read-only but answer OKAY
    wr_hit  = (waddr_r[7:5] == 3'h0) & (waddr_r[1:0] == 2'h0);
  end

  // Read channel; data is registered at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `TPLIC_RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_hs) begin
        rdata_r <= 32'h0000_0000;
        rresp_r <= `TPLIC_RESP_OKAY;
        case (axi_req.araddr)
          `TPLIC_OFF_ICR: begin
            rdata_r[`TPLIC_ICR_HI]       <= glb_hi_r;
            rdata_r[`TPLIC_ICR_LO]       <= glb_lo_r;
            rdata_r[`TPLIC_ICR_CHG_EN]   <= chg_en_r;
            rdata_r[`TPLIC_ICR_EXT_EN]   <= ext_en_r;
            rdata_r[`TPLIC_ICR_EXT_FLAG] <= flags[IEXT];
            rdata_r[`TPLIC_ICR_CHG_FLAG] <= flags[ICHG];
          end
          `TPLIC_OFF_RCR: begin
            rdata_r[`TPLIC_RCR_PME] <= priority_mode_enable_r;
          end
          `TPLIC_OFF_FLAG: begin
            rdata_r[NPER-1:0] <= flags[NPER-1:0];
          end
          `TPLIC_OFF_EN: begin
            rdata_r[NPER-1:0] <= per_en_r;
          end
          `TPLIC_OFF_PRI: begin
            rdata_r[NPER-1:0] <= per_pri_r;
          end
          `TPLIC_OFF_CFG: begin
            rdata_r[`TPLIC_CFG_EDGE]    <= ext0_edge_select_r;
            rdata_r[`TPLIC_CFG_EXT_PRI] <= ext_pri_r;
            rdata_r[`TPLIC_CFG_CHG_PRI] <= chg_pri_r;
          end
          `TPLIC_OFF_PORT: begin
            rdata_r[NCHG-1:0] <= change_sense_port;
          end
          `TPLIC_OFF_STAT: begin
            rdata_r[`TPLIC_STAT_HI]  <= in_high_r;
            rdata_r[`TPLIC_STAT_LO]  <= in_low_r;
            rdata_r[`TPLIC_STAT_ARM] <= (state_r == TPLIC_ARMED);
          end
          default: begin
            rresp_r <= `TPLIC_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Enables and priorities written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chg_en_r               <= 1'b0;
      ext_en_r               <= 1'b0;
      priority_mode_enable_r <= 1'b0;
      per_en_r               <= '0;
      per_pri_r              <= '1;
      ext0_edge_select_r     <= `TPLIC_RST_EDGE;
      ext_pri_r              <= `TPLIC_RST_PRI;
      chg_pri_r              <= `TPLIC_RST_PRI;
    end else begin
      if (wr_icr) begin
        chg_en_r <= wdata_r[`TPLIC_ICR_CHG_EN];
        ext_en_r <= wdata_r[`TPLIC_ICR_EXT_EN];
      end
      if (wr_rcr) begin
        priority_mode_enable_r <= wdata_r[`TPLIC_RCR_PME];
      end
      if (wr_en) begin
        per_en_r <= wdata_r[NPER-1:0];
      end
      if (wr_pri) begin
        per_pri_r <= wdata_r[NPER-1:0];
      end
      if (wr_cfg) begin
        ext0_edge_select_r <= wdata_r[`TPLIC_CFG_EDGE];
        ext_pri_r          <= wdata_r[`TPLIC_CFG_EXT_PRI];
        chg_pri_r          <= wdata_r[`TPLIC_CFG_CHG_PRI];
      end
    end
  end

  // Pins sampled at boundaries so latency is counted in instructions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_smp_r  <= 1'b0;
      ext_prev_r <= 1'b0;
      chg_smp_r  <= '0;
    end else if (instr_boundary) begin
      ext_smp_r  <= ext0_pin;
      ext_prev_r <= ext_smp_r;
      chg_smp_r  <= change_sense_port;
    end
  end

  // Port read ends the mismatch by taking a fresh reference
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_latch_r <= '0;
    end else if (ar_hs && (axi_req.araddr == `TPLIC_OFF_PORT)) begin
      port_latch_r <= change_sense_port;
    end
  end

  // Event detection; flags set with no regard to any enable
  always_comb begin
    ext_edge = ext0_edge_select_r ? (ext_smp_r & ~ext_prev_r)
                                  : (~ext_smp_r & ext_prev_r);
    chg_mis  = (chg_smp_r != port_latch_r);
    ev_set   = {chg_mis, ext_edge, per_event};
  end

  // Software writes reach flags through their own registers
  always_comb begin
    fl_wr  = {wr_icr, wr_icr, {NPER{wr_flag}}};
    fl_val = {wdata_r[`TPLIC_ICR_CHG_FLAG], wdata_r[`TPLIC_ICR_EXT_FLAG], wdata_r[NPER-1:0]};
  end

  // Pending flags, one per source
  tplic_flag_bank #(
    .N (NSRC)
  ) u_flags (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_i   (ev_set),
    .wr_en   (fl_wr),
    .wr_val  (fl_val),
    .flags_r (flags)
  );

  // Per-source qualification
  always_comb begin
    src_en  = {chg_en_r, ext_en_r, per_en_r};
    src_pri = {chg_pri_r, ext_pri_r, per_pri_r};
    src_per = {2'b00, {NPER{1'b1}}};
    active  = flags & src_en;
  end

  // Global gating per mode
  always_comb begin
    // Compatibility: bit6 gates peripherals, bit7 gates all
    cmp_req = glb_hi_r & (|(active & (~src_per | {NSRC{glb_lo_r}})));
    hi_req  = glb_hi_r & (|(active & src_pri));
    // Low held off while a high routine runs
    lo_req  = glb_lo_r & ~in_high_r & (|(active & ~src_pri));
    // Priority bits only matter in priority mode
    take_hi = priority_mode_enable_r ? hi_req : cmp_req;
    take_lo = priority_mode_enable_r & lo_req & ~hi_req;
    fire    = instr_boundary & (state_r == TPLIC_ARMED) &
              (arm_cnt_r == 2'h0) & (take_hi | take_lo);
  end

  // Acceptance sequencer; a withdrawn request disarms
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r   <= TPLIC_IDLE;
      arm_cnt_r <= 2'h0;
    end else begin
      case (state_r)
        TPLIC_IDLE: begin
          if (instr_boundary && (take_hi || take_lo)) begin
            state_r   <= TPLIC_ARMED;
            arm_cnt_r <= `TPLIC_ARM_CYCLES - 2'h1;
          end
        end
        TPLIC_ARMED: begin
          if (!(take_hi || take_lo)) begin
            state_r <= TPLIC_IDLE;
          end else if (instr_boundary) begin
            if (arm_cnt_r == 2'h0) begin
              state_r <= TPLIC_IDLE;
            end else begin
              arm_cnt_r <= arm_cnt_r - 2'h1;
            end
          end
        end
        default: begin
          state_r <= TPLIC_IDLE;
        end
      endcase
    end
  end

  // Redirection to the core; high preempts a running low routine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      redirect_r <= 1'b0;
      push_r     <= 1'b0;
      vector_r   <= `TPLIC_VEC_HIGH;
    end else begin
      redirect_r <= fire;
      push_r     <= fire;
      if (fire) begin
        // Compatibility mode takes the high path only
        vector_r <= take_hi ? `TPLIC_VEC_HIGH : `TPLIC_VEC_LOW;
      end
    end
  end

  // Global enables: acceptance clears, return sets, software writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      glb_hi_r <= 1'b0;
      glb_lo_r <= 1'b0;
    end else if (fire) begin
      if (take_hi) begin
        glb_hi_r <= 1'b0;
      end else begin
        glb_lo_r <= 1'b0;
      end
    end else if (ret_op) begin
      // Innermost routine decides which enable comes back
      if (!priority_mode_enable_r || in_high_r) begin
        glb_hi_r <= 1'b1;
      end else if (in_low_r) begin
        glb_lo_r <= 1'b1;
      end
    end else if (wr_icr) begin
      glb_hi_r <= wdata_r[`TPLIC_ICR_HI];
      glb_lo_r <= wdata_r[`TPLIC_ICR_LO];
    end
  end

  // Service levels in progress
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_high_r <= 1'b0;
      in_low_r  <= 1'b0;
    end else if (fire) begin
      if (take_hi) begin
        in_high_r <= 1'b1;
      end else begin
        in_low_r <= 1'b1;
      end
    end else if (ret_op) begin
      if (in_high_r) begin
        in_high_r <= 1'b0;
      end else begin
        in_low_r <= 1'b0;
      end
    end
  end

  // Outputs straight from flops
  always_comb begin
    axi_rsp.awready      = awready_r;
    axi_rsp.wready       = wready_r;
    axi_rsp.bvalid       = bvalid_r;
    axi_rsp.bresp        = bresp_r;
    axi_rsp.arready      = arready_r;
    axi_rsp.rvalid       = rvalid_r;
    axi_rsp.rdata        = rdata_r;
    axi_rsp.rresp        = rresp_r;
    core_out.redirect    = redirect_r;
    core_out.push_return = push_r;
    core_out.vector      = vector_r;
  end

endmodule
`default_nettype wire

// ===== tb/tplic_chk.sv
// Purpose: Port checks for the irq controller
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound into tplic_top below
`timescale 1ns/10ps
`default_nettype none
module tplic_chk (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire tplic_pkg::tplic_axil_req_t axi_req,
  input wire tplic_pkg::tplic_axil_rsp_t axi_rsp,
  input wire logic                       instr_boundary,
  input wire tplic_pkg::tplic_core_t     core_out
);
  import tplic_pkg::*;
  // One domain, so clock and reset once
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Both write halves taken at one edge
  sequence s_wr_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  // Read address taken
  sequence s_rd_taken;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  AST_ENTRY_ADDR: assert property (core_out.redirect |-> core_out.vector inside {16'h0008, 16'h0018})
    else $error("entry address off vector");
  AST_PUSH_WITH_LOAD: assert property (core_out.redirect == core_out.push_return)
    else $error("push and redirect apart");
  AST_AT_BOUNDARY: assert property (core_out.redirect |-> $past(instr_boundary))
    else $error("redirect off boundary");
  AST_ONE_PULSE: assert property (core_out.redirect |=> !core_out.redirect)
    else $error("redirect longer than a cycle");
  AST_VEC_STEADY: assert property ($changed(core_out.vector) |-> core_out.redirect)
    else $error("vector moved without redirect");
  // Both halves are held for one edge before the write lands, so the answer shows two edges on
  AST_WR_ANSWER: assert property (s_wr_taken |=> ##1 axi_rsp.bvalid)
    else $error("write answer late");
  AST_RD_ANSWER: assert property (s_rd_taken |=> axi_rsp.rvalid)
    else $error("read answer late");
  AST_B_DROPS: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
    else $error("write answer repeated");
endmodule
bind tplic_top tplic_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .instr_boundary(instr_boundary), .core_out(core_out)
);
`default_nettype wire

// ===== tb/tplic_core_model.sv
// Purpose: Core sequencer stand-in
// Assumes: Redirect is a one-cycle pulse
// Notes:   Slow stretches the instruction cycle
`timescale 1ns/10ps
`default_nettype none
module tplic_core_model (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   slow,
  input  wire logic                   ret_req,
  input  wire tplic_pkg::tplic_core_t core_in,
  output var  logic                   instr_boundary,
  output var  logic                   ret_op,
  output var  logic [15:0]            pc,
  output var  logic [7:0]             n_entry
);
  import tplic_pkg::*;
  logic [2:0] cyc_r; // Clock within the instruction
  // Free-running instruction cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_r <= 3'h0;
    end else begin
      cyc_r <= cyc_r + 3'h1;
    end
  end
  // One boundary per 4 or 8 clocks
  assign instr_boundary = slow ? (cyc_r == 3'h7) : (cyc_r[1:0] == 2'h3);
  // Load PC and count the entry on redirect with push_return
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc      <= 16'h0;
      n_entry <= 8'h0;
    end else if (core_in.redirect && core_in.push_return) begin
      pc      <= core_in.vector;
      n_entry <= n_entry + 8'h1;
    end
  end
  // Return op, one clock after the request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ret_op <= 1'b0;
    end else begin
      ret_op <= ret_req;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tplic_bench.sv
// Purpose: Bus-level tests of the irq controller
// Assumes: Core model paces boundaries
// Notes:   Entries counted in the core model
`timescale 1ns/10ps
`default_nettype none
module tplic_bench;
  import tplic_pkg::*;
  logic            aclk;
  logic            aresetn;
  logic            ext0_pin;
  logic            ret_req;
  logic            slow;
  logic            bnd;
  logic            ret_op;
  logic [3:0]      pins;
  logic [7:0]      ev_r;
  logic [7:0]      n_entry;
  logic [7:0]      n_bnd = 8'h0;
  logic [7:0]      b0;
  logic [15:0]     pc;
  logic [31:0]     rdat;
  logic [1:0]      rr;
  logic [1:0]      br;
  tplic_axil_req_t req;
  tplic_axil_rsp_t rsp;
  tplic_core_t     core;
  int              n_errors = 0;
  int              n_checks = 0;
  // 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Boundaries seen, for latency
  always @(posedge aclk) if (bnd) n_bnd <= n_bnd + 8'h1;
  tplic_top #(.NPER(8), .NCHG(4)) dut (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .instr_boundary(bnd),
    .ret_op(ret_op), .ext0_pin(ext0_pin), .change_sense_port(pins), .per_event(ev_r), .core_out(core)
  );
  tplic_core_model u_core (
    .aclk(aclk), .aresetn(aresetn), .slow(slow), .ret_req(ret_req), .core_in(core),
    .instr_boundary(bnd), .ret_op(ret_op), .pc(pc), .n_entry(n_entry)
  );
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Write: both halves offered, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: {24'h0, d}, wstrb: 4'hf, bready: 1'b1, default: '0};
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    br = rsp.bresp;
    req <= '0;
    @(posedge aclk);
  endtask
  // Read and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    rdat = rsp.rdata;
    rr = rsp.rresp;
    req <= '0;
    @(posedge aclk);
    chk(rdat, e);
  endtask
  task automatic ev(input logic [7:0] m);
    ev_r <= m;
    @(posedge aclk);
    ev_r <= 8'h0;
  endtask
  // Wait, bounded, for one entry
  task automatic entry(input logic [15:0] v);
    logic [7:0] b;
    b = n_entry;
    repeat (80) if (n_entry == b) @(posedge aclk);
    chk(n_entry, b + 8'h1);
    chk(pc, v);
  endtask
  task automatic none();
    logic [7:0] b;
    b = n_entry;
    repeat (40) @(posedge aclk);
    chk(n_entry, b);
  endtask
  task automatic ret();
    ret_req <= 1'b1;
    @(posedge aclk);
    ret_req <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog well past the test length
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    $display("BAD t=%0t watchdog expired", $time);
    final_report();
  end
  initial begin
    {aresetn, ext0_pin, ret_req, slow, pins, ev_r} = '0;
    req = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h10, 32'hff);
    rdc(8'h14, 32'h43);
    rdc(8'h20, 32'h0);
    chk(rr, 2'h2);
    wr(8'h20, 8'h5a);
    chk(br, 2'h2);
    ev(8'h0c);
    rdc(8'h08, 32'h0c);
    $display("test reset and polling done");
    wr(8'h08, 8'h00);
    wr(8'h10, 8'h00);
    wr(8'h0c, 8'h04);
    chk(br, 2'h0);
    wr(8'h00, 8'h80);
    ev(8'h04);
    none();
    wr(8'h08, 8'h00);
    wr(8'h00, 8'hc0);
    ev(8'h08);
    none();
    ev(8'h04);
    entry(16'h0008);
    rdc(8'h00, 32'h40);
    wr(8'h08, 8'h00);
    ret();
    rdc(8'h00, 32'hc0);
    $display("test compatibility done");
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h80);
    wr(8'h10, 8'h01);
    wr(8'h0c, 8'h05);
    wr(8'h00, 8'hc0);
    ev(8'h04);
    entry(16'h0018);
    rdc(8'h00, 32'h80);
    ev(8'h01);
    entry(16'h0008);
    rdc(8'h1c, 32'h03);
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h40);
    ev(8'h04);
    none();
    wr(8'h08, 8'h00);
    ret();
    rdc(8'h00, 32'hc0);
    ret();
    rdc(8'h1c, 32'h00);
    slow <= 1'b1;
    ev(8'h05);
    entry(16'h0008);
    rdc(8'h00, 32'h40);
    wr(8'h08, 8'h00);
    ret();
    $display("test priority done");
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h90);
    b0 = n_bnd;
    ext0_pin <= 1'b1;
    entry(16'h0008);
    chk((n_bnd - b0) inside {8'h03, 8'h04}, 1'b1);
    rdc(8'h00, 32'h12);
    wr(8'h00, 8'h10);
    wr(8'h14, 8'h03);
    ext0_pin <= 1'b0;
    repeat (24) @(posedge aclk);
    rdc(8'h00, 32'h12);
    wr(8'h00, 8'h10);
    ext0_pin <= 1'b1;
    repeat (24) @(posedge aclk);
    rdc(8'h00, 32'h10);
    $display("test pin edge done");
    rdc(8'h18, 32'h0);
    pins <= 4'h5;
    repeat (24) @(posedge aclk);
    wr(8'h00, 8'h00);
    repeat (24) @(posedge aclk);
    rdc(8'h00, 32'h01);
    rdc(8'h18, 32'h05);
    wr(8'h00, 8'h00);
    repeat (24) @(posedge aclk);
    rdc(8'h00, 32'h00);
    $display("test port change done");
    final_report();
  end
endmodule
`default_nettype wire
